// ===== rtl/spb_device.sv
// spb_device: device end, shifts words in, echoes the previous word, drives busy
// assumes MCLK runs much faster than the link clock, which it samples
`timescale 1ns/100ps
`default_nettype none
module spb_device #(
   parameter int RESET_BUSY = spb_pkg::RESET_BUSY_CYCLES,
   parameter int BUSY_HOLD = spb_pkg::BUSY_HOLD_CYCLES
) (
   input wire logic MCLK,
   input wire logic RSTN,
   spb_link_if.dev LINK,
   output logic [spb_pkg::WORD_BITS-1:0] RX_WORD,
   output logic RX_VALID,
   output logic BUSY_ACTIVE
);
   initial begin
      if (BUSY_HOLD < spb_pkg::BUSY_HOLD_MIN || BUSY_HOLD > spb_pkg::BUSY_HOLD_MAX)
         $error("busy hold out of range");
      if (RESET_BUSY < 1) $error("reset busy too short");
   end
   // ----------------------------------------------------------------------
   // pin synchronisers: three stages, change counts when stage 2 and 3 agree
   // ----------------------------------------------------------------------
   logic [2:0] sclk_s_reg, cs_s_reg, sdi_s_reg;
   logic sclk_q_reg, cs_q_reg;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_s_reg <= 3'h0;
         cs_s_reg <= 3'h7;
         sdi_s_reg <= 3'h0;
      end else begin
         sclk_s_reg <= {sclk_s_reg[1:0], LINK.sclk};
         cs_s_reg <= {cs_s_reg[1:0], LINK.cs_n};
         sdi_s_reg <= {sdi_s_reg[1:0], LINK.sdi};
      end
   end
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_q_reg <= 1'b0;
         cs_q_reg <= 1'b1;
      end else begin
         if (sclk_s_reg[1] == sclk_s_reg[2]) sclk_q_reg <= sclk_s_reg[2];
         if (cs_s_reg[1] == cs_s_reg[2]) cs_q_reg <= cs_s_reg[2];
      end
   end
   logic sclk_next;
   logic rise;
   logic fall;
   assign sclk_next = (sclk_s_reg[1] == sclk_s_reg[2]) ? sclk_s_reg[2] : sclk_q_reg;
   assign rise = sclk_next && !sclk_q_reg;
   assign fall = !sclk_next && sclk_q_reg;
   // ----------------------------------------------------------------------
   // reset release recognised on the next rising link edge
   // ----------------------------------------------------------------------
   logic armed_reg;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) armed_reg <= 1'b0;
      else if (rise) armed_reg <= 1'b1;
   end
   // ----------------------------------------------------------------------
   // shift register and frame tracking
   // ----------------------------------------------------------------------
   logic [spb_pkg::WORD_BITS-1:0] shift_reg, last_reg;
   logic [5:0] bits_reg;
   logic was_sel_reg;
   logic frame_end;
   assign frame_end = rise && cs_q_reg && was_sel_reg;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         shift_reg <= 24'h000000;
         bits_reg <= 6'h00;
         was_sel_reg <= 1'b0;
      end else if (rise && armed_reg) begin
         was_sel_reg <= !cs_q_reg;
         if (!cs_q_reg) begin
            shift_reg <= {shift_reg[spb_pkg::WORD_BITS-2:0], sdi_s_reg[2]};
            if (bits_reg != 6'h3F) bits_reg <= bits_reg + 6'h01;
         end else begin
            bits_reg <= 6'h00;
         end
      end
   end
   // a frame is valid only with a whole word shifted in
   logic valid_end;
   assign valid_end = frame_end && armed_reg && bits_reg == 6'(spb_pkg::WORD_BITS);
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         RX_WORD <= 24'h000000;
         RX_VALID <= 1'b0;
         last_reg <= 24'h000000;
      end else begin
         RX_VALID <= valid_end;
         if (valid_end) begin
            RX_WORD <= shift_reg;
            last_reg <= shift_reg;
         end
      end
   end
   // ----------------------------------------------------------------------
   // serial output: previous word, new bit launched after each rising edge
   // ----------------------------------------------------------------------
   logic [spb_pkg::WORD_BITS-1:0] out_reg;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         out_reg <= 24'h000000;
         LINK.sdo_o <= 1'b0;
         LINK.sdo_oe <= 1'b0;
      end else begin
         LINK.sdo_oe <= !cs_q_reg;
         if (cs_q_reg) begin
            out_reg <= last_reg;
            LINK.sdo_o <= last_reg[spb_pkg::WORD_BITS-1];
         end else if (rise) begin
            out_reg <= {out_reg[spb_pkg::WORD_BITS-2:0], 1'b0};
            LINK.sdo_o <= out_reg[spb_pkg::WORD_BITS-2];
         end
      end
   end
   // ----------------------------------------------------------------------
   // busy: count link rising edges; long count after any reset
   // ----------------------------------------------------------------------
   logic [9:0] busy_cnt_reg;
   logic busy_reg;
   logic soft_rst;
   assign soft_rst = shift_reg[spb_pkg::SOFT_RESET_BIT];
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_reg <= 1'b1;
         busy_cnt_reg <= 10'(RESET_BUSY);
      end else if (rise) begin
         if (!armed_reg) begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= 10'(RESET_BUSY - 1);
         end else if (valid_end) begin
            busy_reg <= 1'b1;
            busy_cnt_reg <= soft_rst ? 10'(RESET_BUSY - 1) : 10'(BUSY_HOLD - 1);
         end else if (busy_cnt_reg != 10'h000) begin
            busy_cnt_reg <= busy_cnt_reg - 10'h001;
         end else begin
            busy_reg <= 1'b0;
         end
      end
   end
   // open drain: output level fixed low, enable carries assertion
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         LINK.busy_n_o <= 1'b0;
         LINK.busy_n_oe <= 1'b0;
         BUSY_ACTIVE <= 1'b0;
      end else begin
         LINK.busy_n_o <= 1'b0;
         LINK.busy_n_oe <= busy_reg && armed_reg;
         BUSY_ACTIVE <= busy_reg && armed_reg;
      end
   end
   logic unused_fall;
   assign unused_fall = fall;
endmodule : spb_device
`default_nettype wire

// ===== rtl/spb_pkg.sv
// spb_pkg: shared constants of the serial port busy sequencer
// assumes both ends and the bench compile this package first
package spb_pkg;
   // ----------------------------------------------------------------------
   // frame and timing
   // ----------------------------------------------------------------------
   localparam int WORD_BITS = 24;
   localparam int CS_RELEASE_GAP_CYCLES = 3;
   localparam int MIN_CYCLES_PER_WORD = 29;
   localparam int BUSY_HOLD_CYCLES = 4;
   localparam int BUSY_HOLD_MIN = 3;
   localparam int BUSY_HOLD_MAX = 21;
   localparam int RESET_BUSY_CYCLES = 744;
   localparam int LEVEL_SETTLE_TIME_NS = 10000;
   localparam int MCLK_PERIOD_NS = 4;
   localparam int LEVEL_SETTLE_CYCLES = LEVEL_SETTLE_TIME_NS / MCLK_PERIOD_NS;
   localparam int SCLK_HALF_DIV = 6;
   // ----------------------------------------------------------------------
   // word layout: bit 23 software reset request, rest is payload
   // ----------------------------------------------------------------------
   localparam int SOFT_RESET_BIT = 23;
endpackage : spb_pkg

// ===== rtl/spb_link_if.sv
// spb_link_if: serial link between host and device
// assumes the bench resolves the open-drain busy and tristate data wires
`timescale 1ns/100ps
`default_nettype none
interface spb_link_if;
   logic cs_n;
   logic sclk;
   logic sdi;
   logic sdo_o;
   logic sdo_oe;
   logic sdo;
   logic busy_n_o;
   logic busy_n_oe;
   logic busy_n;
   modport dev (input cs_n, input sclk, input sdi, output sdo_o, output sdo_oe,
      output busy_n_o, output busy_n_oe);
   modport host (output cs_n, output sclk, output sdi, input sdo, input busy_n);
endinterface : spb_link_if
`default_nettype wire

// ===== rtl/spb_host.sv
// spb_host: host end, makes the link clock, sends words, waits out busy
// assumes the bench pulls busy high when nobody sinks it
`timescale 1ns/100ps
`default_nettype none
module spb_host #(
   parameter int HALF_DIV = spb_pkg::SCLK_HALF_DIV
) (
   input wire logic MCLK,
   input wire logic RSTN,
   spb_link_if.host LINK,
   input wire logic [spb_pkg::WORD_BITS-1:0] TX_WORD,
   input wire logic TX_START,
   output logic TX_READY,
   output logic [spb_pkg::WORD_BITS-1:0] RX_WORD,
   output logic RX_VALID
);
   initial begin
      if (HALF_DIV < 2) $error("clock divider too small");
   end
   typedef enum logic [1:0] {H_IDLE, H_SHIFT, H_GAP} spb_hstate_t;
   spb_hstate_t state_reg;
   logic [7:0] div_reg;
   logic [5:0] cnt_reg;
   logic [spb_pkg::WORD_BITS-1:0] tx_reg, rx_reg;
   logic pending_reg;
   logic [2:0] busy_s_reg, sdo_s_reg;
   logic busy_q_reg;
   logic tick_rise, tick_fall;
   assign tick_rise = !LINK.sclk && div_reg == 8'(HALF_DIV - 1);
   assign tick_fall = LINK.sclk && div_reg == 8'(HALF_DIV - 1);
   // ----------------------------------------------------------------------
   // free running divided link clock, kept running for busy
   // ----------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         div_reg <= 8'h00;
         LINK.sclk <= 1'b0;
      end else if (div_reg == 8'(HALF_DIV - 1)) begin
         div_reg <= 8'h00;
         LINK.sclk <= !LINK.sclk;
      end else begin
         div_reg <= div_reg + 8'h01;
      end
   end
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_s_reg <= 3'h0;
         sdo_s_reg <= 3'h0;
         busy_q_reg <= 1'b0;
      end else begin
         busy_s_reg <= {busy_s_reg[1:0], LINK.busy_n};
         sdo_s_reg <= {sdo_s_reg[1:0], LINK.sdo};
         if (busy_s_reg[1] == busy_s_reg[2]) busy_q_reg <= busy_s_reg[2];
      end
   end
   // ----------------------------------------------------------------------
   // transaction sequencer
   // ----------------------------------------------------------------------
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         state_reg <= H_IDLE;
         cnt_reg <= 6'h00;
         tx_reg <= 24'h000000;
         rx_reg <= 24'h000000;
         pending_reg <= 1'b0;
         LINK.cs_n <= 1'b1;
         LINK.sdi <= 1'b0;
         TX_READY <= 1'b0;
         RX_WORD <= 24'h000000;
         RX_VALID <= 1'b0;
      end else begin
         RX_VALID <= 1'b0;
         TX_READY <= !pending_reg && state_reg == H_IDLE && !TX_START;
         if (TX_START && !pending_reg && state_reg == H_IDLE) begin
            pending_reg <= 1'b1;
            tx_reg <= TX_WORD;
         end
         case (state_reg)
            H_IDLE: begin
               // start at a falling edge once busy has released
               if (pending_reg && busy_q_reg && tick_fall) begin
                  LINK.cs_n <= 1'b0;
                  LINK.sdi <= tx_reg[spb_pkg::WORD_BITS-1];
                  cnt_reg <= 6'h00;
                  state_reg <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick_rise) begin
                  tx_reg <= {tx_reg[spb_pkg::WORD_BITS-2:0], 1'b0};
                  cnt_reg <= cnt_reg + 6'h01;
               end
               if (tick_fall) begin
                  // sample half a period late: the device launches after the rise and
                  // the returning bit still needs three flip-flops to reach us
                  rx_reg <= {rx_reg[spb_pkg::WORD_BITS-2:0], sdo_s_reg[2]};
                  if (cnt_reg == 6'(spb_pkg::WORD_BITS)) begin
                     LINK.cs_n <= 1'b1;
                     cnt_reg <= 6'(spb_pkg::WORD_BITS);
                     state_reg <= H_GAP;
                  end else begin
                     LINK.sdi <= tx_reg[spb_pkg::WORD_BITS-1];
                  end
               end
            end
            H_GAP: begin
               // released gap plus word must reach the minimum edge count
               if (tick_rise) cnt_reg <= cnt_reg + 6'h01;
               if (cnt_reg >= 6'(spb_pkg::MIN_CYCLES_PER_WORD) &&
                  cnt_reg >= 6'(spb_pkg::WORD_BITS + spb_pkg::CS_RELEASE_GAP_CYCLES)) begin
                  RX_WORD <= rx_reg;
                  RX_VALID <= 1'b1;
                  pending_reg <= 1'b0;
                  state_reg <= H_IDLE;
               end
            end
            default: state_reg <= H_IDLE;
         endcase
      end
   end
endmodule : spb_host
`default_nettype wire

// ===== verif/spb_link_asserts.sv
// spb_link_asserts: timing checks on the serial link between host and device
// assumes MCLK oversamples sclk and busy_n is resolved with a pull-up
`timescale 1ns/100ps
`default_nettype none
module spb_link_asserts #(
   parameter int RESET_BUSY = 744
) (
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic cs_n,
   input wire logic sclk,
   input wire logic sdo_o,
   input wire logic sdo_oe,
   input wire logic busy_n_o,
   input wire logic busy_n_oe,
   input wire logic busy_n
);
   // ----------------------------------------
   // link clock edges and counts
   // ----------------------------------------
   localparam int MAXW = RESET_BUSY > 21 ? RESET_BUSY : 21;
   logic sclk_reg, rst_phase_reg;
   logic [3:0] since_reg;
   logic [15:0] busy_reg, gap_reg, word_reg;
   wire logic rise = sclk & ~sclk_reg;
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         sclk_reg <= 1'b0;
         since_reg <= 4'hF;
      end else begin
         sclk_reg <= sclk;
         since_reg <= rise ? 4'h0 : since_reg + {3'h0, since_reg != 4'hF};
      end
   end
   // saturated at reset so the first frame passes the spacing checks
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         gap_reg <= 16'hFFFF;
         word_reg <= 16'hFFFF;
      end else begin
         gap_reg <= !cs_n ? 16'h0 : gap_reg + {15'h0, rise && gap_reg != 16'hFFFF};
         word_reg <= $fell(cs_n) ? 16'h0 : word_reg + {15'h0, rise && word_reg != 16'hFFFF};
      end
   end
   always_ff @(posedge MCLK or negedge RSTN) begin
      if (!RSTN) begin
         busy_reg <= 16'h0;
         rst_phase_reg <= 1'b1;
      end else begin
         busy_reg <= !busy_n_oe ? 16'h0 : busy_reg + {15'h0, rise};
         rst_phase_reg <= rst_phase_reg & ~$fell(busy_n_oe);
      end
   end
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!RSTN);
   sequence s_release;
      $rose(cs_n) ##[1:13] rise;
   endsequence
   a_busy_follows: assert property (s_release |-> ##[1:8] busy_n_oe)
      else $error("busy not raised after select release");
   a_busy_clear_sel: assert property ($fell(cs_n) |-> busy_n && !busy_n_oe)
      else $error("select asserted while busy");
   a_busy_min_width: assert property ($fell(busy_n_oe) |-> busy_reg >= 16'h3)
      else $error("busy released too early");
   a_busy_max_width: assert property (busy_n_oe |-> busy_reg <= MAXW)
      else $error("busy held too long");
   a_reset_busy_long: assert property ($fell(busy_n_oe) && rst_phase_reg |-> busy_reg >= RESET_BUSY)
      else $error("reset busy too short");
   a_busy_on_sclk: assert property ($changed(busy_n_oe) |-> since_reg <= 4'h8)
      else $error("busy changed away from a link clock edge");
   a_busy_open_drain: assert property (busy_n == !busy_n_oe && !(busy_n_oe && busy_n_o))
      else $error("busy line not open drain");
   a_sdo_after_rise: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo_o) |-> since_reg <= 4'h8)
      else $error("data out changed away from a rising edge");
   a_sdo_released: assert property (cs_n [*8] |-> !sdo_oe)
      else $error("data out driven while not selected");
   a_sdo_driven: assert property ($fell(cs_n) |-> ##[1:8] sdo_oe)
      else $error("data out not driven while selected");
   a_cs_gap: assert property ($fell(cs_n) |-> gap_reg >= 16'h3)
      else $error("select released too briefly");
   a_word_span: assert property ($fell(cs_n) |-> word_reg >= 16'h1D)
      else $error("word shorter than minimum edges");
   a_reset_quiet: assert property (disable iff (1'b0) !RSTN |-> !busy_n_oe && !sdo_oe && cs_n)
      else $error("outputs active during reset");
endmodule : spb_link_asserts
`default_nettype wire

// ===== verif/tb.sv
// tb: drives the host user side and watches the device user side
// assumes both ends, the link interface and the checker compile first
`timescale 1ns/100ps
`default_nettype none
module tb;
   // ----------------------------------------
   // link, ends and checker
   // ----------------------------------------
   localparam int RB = 8;
   logic mclk = 1'b0;
   logic rstn = 1'b1;
   logic flip = 1'b0;
   logic tx_start = 1'b0;
   logic [23:0] tx_word = 24'h0;
   logic tx_ready, dev_valid, host_valid, busy_active;
   logic [23:0] dev_word, host_word, d_got, h_got;
   logic [23:0] words [4] = '{24'hA5C3F0, 24'h7FFFFF, 24'h000001, 24'h800001};
   int fails = 0;
   int n_checks = 0;
   int n;
   spb_link_if link ();
   // a released data line must not look like a stable bit
   assign link.sdo = link.sdo_oe ? link.sdo_o : flip;
   assign link.busy_n = link.busy_n_oe ? link.busy_n_o : 1'b1;
   initial forever #2 mclk = ~mclk;
   always @(posedge mclk) flip <= ~flip;
   spb_device #(.RESET_BUSY(RB), .BUSY_HOLD(spb_pkg::BUSY_HOLD_CYCLES)) spb_device_inst (
      .MCLK(mclk), .RSTN(rstn), .LINK(link), .RX_WORD(dev_word), .RX_VALID(dev_valid),
      .BUSY_ACTIVE(busy_active));
   spb_host #(.HALF_DIV(spb_pkg::SCLK_HALF_DIV)) spb_host_inst (.MCLK(mclk), .RSTN(rstn),
      .LINK(link), .TX_WORD(tx_word), .TX_START(tx_start), .TX_READY(tx_ready),
      .RX_WORD(host_word), .RX_VALID(host_valid));
   spb_link_asserts #(.RESET_BUSY(RB)) spb_link_asserts_inst (.MCLK(mclk), .RSTN(rstn),
      .cs_n(link.cs_n), .sclk(link.sclk), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe),
      .busy_n_o(link.busy_n_o), .busy_n_oe(link.busy_n_oe), .busy_n(link.busy_n));
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic give_up();
      fails++;
      $display("unexpected wait: expected done seen timeout");
      print_verdict();
   endtask : give_up
   task automatic start(input logic [23:0] w);
      int i;
      for (i = 0; i < 4000 && tx_ready !== 1'b1; i++) @(posedge mclk);
      if (i >= 4000) give_up();
      tx_word <= w;
      tx_start <= 1'b1;
      @(posedge mclk);
      tx_start <= 1'b0;
   endtask : start
   // counts link rising edges seen while the device reports busy
   task automatic run(input logic [23:0] w, input bit send);
      int i;
      bit seen, dg, hg;
      logic sp;
      seen = 1'b0;
      dg = !send;
      hg = !send;
      n = 0;
      sp = link.sclk;
      if (send) start(w);
      for (i = 0; i < 40000 && !(seen && busy_active === 1'b0 && dg && hg); i++) begin
         @(posedge mclk);
         if (dev_valid === 1'b1) begin
            dg = 1'b1;
            d_got = dev_word;
         end
         if (host_valid === 1'b1) begin
            hg = 1'b1;
            h_got = host_word;
         end
         if (busy_active === 1'b1 && !seen) check("busy wire", 24'h0, {23'h0, link.busy_n});
         if (busy_active === 1'b1) begin
            seen = 1'b1;
            n += int'(link.sclk === 1'b1 && sp === 1'b0);
         end
         sp = link.sclk;
      end
      if (i >= 40000) give_up();
   endtask : run
   initial begin
      // a real falling edge, so the asynchronous resets do fire at start
      rstn <= 1'b0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      run(24'h0, 1'b0);
      check("reset busy width", 24'h1, 24'(n >= RB));
      $display("test reset busy done");
      for (int k = 0; k < 4; k++) begin
         run(words[k], 1'b1);
         check("device word", words[k], d_got);
         check("host echo", k > 0 ? words[k-1] : 24'h000000, h_got);
         check("busy width", 24'h1, 24'(k == 3 ? n >= RB : n >= 3 && n <= 21));
      end
      check("data out enable idle", 24'h0, {23'h0, link.sdo_oe});
      $display("test words done");
      start(24'h3C3C3C);
      repeat (150) @(posedge mclk);
      #1 rstn = 1'b0;
      #1 check("reset quiet", 24'h1, {23'h0, link.cs_n & ~link.sdo_oe & ~link.busy_n_oe});
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      run(24'h0, 1'b0);
      check("reset busy width", 24'h1, 24'(n >= RB));
      run(24'h5A0F3C, 1'b1);
      check("device word", 24'h5A0F3C, d_got);
      $display("test mid reset done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
